// [vdft_defines.svh]
/*
  constants for the display frame timing block: register byte offsets,
  field positions, reset values and timing counts.
  assumes inclusion by vdft_pkg and the design modules by bare name.
*/
`ifndef VDFT_DEFINES_SVH
`define VDFT_DEFINES_SVH

`define VDFT_OFS_CTRL        12'h000
`define VDFT_OFS_FRAME_SIZE  12'h004
`define VDFT_OFS_HBLANK      12'h008
`define VDFT_OFS_VBLANK1     12'h00C
`define VDFT_OFS_VBIT1       12'h010
`define VDFT_OFS_STATUS      12'h014

`define VDFT_POS_W           12
`define VDFT_HI_LSB          16
`define VDFT_HI_MSB          27
`define VDFT_LO_MSB          11
`define VDFT_DLY_BIT         15
`define VDFT_MODE_MSB        2
`define VDFT_MODE_RAW_BIT    1

`define VDFT_POS_ZERO        12'h000
`define VDFT_LINE_FIRST      12'h001
`define VDFT_POS_ONE         12'h001
`define VDFT_WORD_ZERO       32'h0000_0000
`define VDFT_MODE_RST        3'h0
`define VDFT_VBIT_RST        24'h00_0000

`define VDFT_DELAY_NS        80
`define VDFT_CLK_NS          20
`define VDFT_DLY_W           3
`define VDFT_DELAY_CYC       3'(`VDFT_DELAY_NS / `VDFT_CLK_NS)
`define VDFT_DLY_ZERO        3'h0
`define VDFT_DLY_ONE         3'h1

`endif

// [vdft_pkg.sv]
/*
  types shared by the display frame timing block.
  assumes vdft_defines.svh is on the include path.
*/
`include "vdft_defines.svh"

package vdft_pkg;

  typedef logic [`VDFT_POS_W-1:0] vdft_pos_t;

  typedef enum logic [1:0] {
    VDFT_BT656,
    VDFT_YC,
    VDFT_RAW
  } vdft_mode_t;

  // timing outputs that travel together to the pins
  typedef struct packed {
    logic horiz_blank_out;
    logic vert_blank_out;
    logic eav_insert;
    logic sav_insert;
    logic f1_vbit;
  } vdft_timing_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } vdft_apb_rsp_t;

endpackage : vdft_pkg

// [vdft_hblank_delay.sv]
/*
  delayed release of horizontal blanking: counts the documented delay
  from a release request and then pulses done.
  assumes one clock, pclk, and asynchronous active-low presetn.
*/
`timescale 1ns/100ps
`include "vdft_defines.svh"

module vdft_hblank_delay (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic start,
  input  wire logic cancel,
  output logic      done
);
  import vdft_pkg::*;

  logic [`VDFT_DLY_W-1:0] cnt_ff;

  // a fresh start restarts the count; cancel wins so a new blank is clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= `VDFT_DLY_ZERO;
    end else if (cancel) begin
      cnt_ff <= `VDFT_DLY_ZERO;
    end else if (start) begin
      cnt_ff <= `VDFT_DELAY_CYC;
    end else if (cnt_ff != `VDFT_DLY_ZERO) begin
      cnt_ff <= cnt_ff - `VDFT_DLY_ONE;
    end
  end

  assign done = (cnt_ff == `VDFT_DLY_ONE) && !cancel && !start;

endmodule : vdft_hblank_delay

// [vdft_frame_timing.sv]
/*
  display frame timing generator with an APB register slave: pixel and
  line counters, horizontal blanking, field 1 vertical blanking start,
  and EAV/SAV insertion strobes.
  assumes APB master on pclk; outputs feed an external display device.
*/
// Behaviour
// - the pixel counter starts at zero, counts to pixels-per-line minus one, then wraps to zero.
// - the line counter starts at one, counts to lines-per-frame, then wraps to one.
// - frame size bits 27..16 hold lines per frame, the line counter end value.
// - frame size bits 11..0 hold pixels per line, the pixel counter end value plus one.
// - horizontal blanking asserts when the pixel counter equals the begin position.
// - in BT.656 and Y/C modes the EAV strobe fires at the begin position.
// - horizontal blanking deasserts when the pixel counter equals the end position.
// - in BT.656 and Y/C modes the SAV strobe fires at the end position.
// - with the delay bit set outside raw mode, blanking falls 4 clocks later.
// - vertical blanking asserts when line and pixel match the field 1 begin point.
// - the field 1 V bit comes from its own register, not from vertical blanking.
// - every line and pixel field is 12 bits and takes any value.
// - in raw mode begin and end bound blanking and no codes are inserted.
// - mode values 0,1 are BT.656, 4,5 are Y/C, 2,3,6,7 are raw.
`timescale 1ns/100ps
`include "vdft_defines.svh"

module vdft_frame_timing (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output vdft_pkg::vdft_apb_rsp_t apb_rsp,
  // display timing
  output vdft_pkg::vdft_timing_t  timing
);
  import vdft_pkg::*;

  // field helpers used by decode and readback
  function automatic vdft_pos_t hi_field(input logic [31:0] w);
    hi_field = w[`VDFT_HI_MSB:`VDFT_HI_LSB];
  endfunction : hi_field

  function automatic vdft_pos_t lo_field(input logic [31:0] w);
    lo_field = w[`VDFT_LO_MSB:0];
  endfunction : lo_field

  function automatic logic [31:0] pack_pair(input vdft_pos_t hi,
                                            input vdft_pos_t lo);
    pack_pair = {4'h0, hi, 4'h0, lo};
  endfunction : pack_pair

  function automatic vdft_mode_t decode_mode(input logic [2:0] m);
    if (m[`VDFT_MODE_RAW_BIT])
      decode_mode = VDFT_RAW;
    else if (m[`VDFT_MODE_MSB])
      decode_mode = VDFT_YC;
    else
      decode_mode = VDFT_BT656;
  endfunction : decode_mode

  // registers
  vdft_pos_t   lines_per_frame_ff;
  vdft_pos_t   pixels_per_line_ff;
  vdft_pos_t   line_blank_begin_pos_ff;
  vdft_pos_t   line_blank_end_pos_ff;
  logic        blank_end_delay_en_ff;
  vdft_pos_t   f1_vblank_begin_line_ff;
  vdft_pos_t   f1_vblank_begin_pixel_ff;
  logic [2:0]  display_mode_select_ff;
  logic        f1_vbit_control_ff;
  vdft_pos_t   frame_pixel_counter_ff;
  vdft_pos_t   frame_line_counter_ff;
  vdft_apb_rsp_t apb_rsp_ff;
  vdft_timing_t  timing_ff;

  vdft_mode_t  mode;
  logic        coded;
  logic        apb_wr;
  logic        pix_wrap;
  logic        at_begin;
  logic        at_end;
  logic        dly_done;
  logic [31:0] nxt_prdata;
  logic        nxt_err;

  assign mode     = decode_mode(display_mode_select_ff);
  assign coded    = (mode != VDFT_RAW);
  assign apb_wr   = psel && penable && pwrite;
  assign pix_wrap = (frame_pixel_counter_ff
                     == pixels_per_line_ff - `VDFT_POS_ONE)
                    || (pixels_per_line_ff == `VDFT_POS_ZERO);
  assign at_begin = (frame_pixel_counter_ff == line_blank_begin_pos_ff);
  assign at_end   = (frame_pixel_counter_ff == line_blank_end_pos_ff);

  // register writes; all position fields take the full 12-bit range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines_per_frame_ff       <= `VDFT_POS_ZERO;
      pixels_per_line_ff       <= `VDFT_POS_ZERO;
      line_blank_begin_pos_ff  <= `VDFT_POS_ZERO;
      line_blank_end_pos_ff    <= `VDFT_POS_ZERO;
      blank_end_delay_en_ff    <= 1'b0;
      f1_vblank_begin_line_ff  <= `VDFT_POS_ZERO;
      f1_vblank_begin_pixel_ff <= `VDFT_POS_ZERO;
      display_mode_select_ff   <= `VDFT_MODE_RST;
      f1_vbit_control_ff       <= 1'b0;
    end else if (apb_wr) begin
      case (paddr)
        `VDFT_OFS_CTRL:
          display_mode_select_ff <= pwdata[`VDFT_MODE_MSB:0];
        `VDFT_OFS_FRAME_SIZE: begin
          lines_per_frame_ff <= hi_field(pwdata);
          pixels_per_line_ff <= lo_field(pwdata);
        end
        `VDFT_OFS_HBLANK: begin
          line_blank_end_pos_ff   <= hi_field(pwdata);
          blank_end_delay_en_ff   <= pwdata[`VDFT_DLY_BIT];
          line_blank_begin_pos_ff <= lo_field(pwdata);
        end
        `VDFT_OFS_VBLANK1: begin
          f1_vblank_begin_line_ff  <= hi_field(pwdata);
          f1_vblank_begin_pixel_ff <= lo_field(pwdata);
        end
        `VDFT_OFS_VBIT1:
          f1_vbit_control_ff <= pwdata[0];
        default: ;
      endcase
    end
  end

  // readback; reserved bits stay zero
  always_comb begin
    nxt_prdata = `VDFT_WORD_ZERO;
    nxt_err    = 1'b0;
    case (paddr)
      `VDFT_OFS_CTRL:
        nxt_prdata = {29'h0, display_mode_select_ff};
      `VDFT_OFS_FRAME_SIZE:
        nxt_prdata = pack_pair(lines_per_frame_ff, pixels_per_line_ff);
      `VDFT_OFS_HBLANK: begin
        nxt_prdata = pack_pair(line_blank_end_pos_ff,
                               line_blank_begin_pos_ff);
        nxt_prdata[`VDFT_DLY_BIT] = blank_end_delay_en_ff;
      end
      `VDFT_OFS_VBLANK1:
        nxt_prdata = pack_pair(f1_vblank_begin_line_ff,
                               f1_vblank_begin_pixel_ff);
      `VDFT_OFS_VBIT1:
        nxt_prdata = {31'h0, f1_vbit_control_ff};
      `VDFT_OFS_STATUS:
        nxt_prdata = pack_pair(frame_line_counter_ff,
                               frame_pixel_counter_ff);
      default:
        nxt_err = 1'b1;
    endcase
  end

  // zero-wait slave: pready rises with the access phase, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp_ff <= '0;
    end else begin
      apb_rsp_ff.pready  <= psel && !penable;
      apb_rsp_ff.pslverr <= psel && !penable && nxt_err;
      if (psel && !penable && !pwrite) begin
        apb_rsp_ff.prdata <= nxt_prdata;
      end
    end
  end

  assign apb_rsp = apb_rsp_ff;

  // pixel counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_pixel_counter_ff <= `VDFT_POS_ZERO;
    end else if (pix_wrap) begin
      frame_pixel_counter_ff <= `VDFT_POS_ZERO;
    end else begin
      frame_pixel_counter_ff <= frame_pixel_counter_ff + `VDFT_POS_ONE;
    end
  end

  // line counter; stepping only on pixel wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_line_counter_ff <= `VDFT_LINE_FIRST;
    end else if (pix_wrap) begin
      if (frame_line_counter_ff >= lines_per_frame_ff) begin
        frame_line_counter_ff <= `VDFT_LINE_FIRST;
      end else begin
        frame_line_counter_ff <= frame_line_counter_ff
                                 + `VDFT_POS_ONE;
      end
    end
  end

  vdft_hblank_delay u_hblank_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (at_end && coded && blank_end_delay_en_ff),
    .cancel  (at_begin),
    .done    (dly_done)
  );

  // timing outputs; begin wins when begin and end coincide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_ff <= '0;
    end else begin
      if (at_begin) begin
        timing_ff.horiz_blank_out <= 1'b1;
      end else if (at_end && !(coded && blank_end_delay_en_ff)) begin
        timing_ff.horiz_blank_out <= 1'b0;
      end else if (dly_done) begin
        timing_ff.horiz_blank_out <= 1'b0;
      end
      // vertical end lies outside this block; begin sets and holds
      if (frame_line_counter_ff == f1_vblank_begin_line_ff
          && frame_pixel_counter_ff == f1_vblank_begin_pixel_ff) begin
        timing_ff.vert_blank_out <= 1'b1;
      end
      timing_ff.eav_insert <= at_begin && coded;
      timing_ff.sav_insert <= at_end && coded;
      timing_ff.f1_vbit    <= f1_vbit_control_ff;
    end
  end

  assign timing = timing_ff;

  // assertions
  a_pixel_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pix_wrap |=> frame_pixel_counter_ff == `VDFT_POS_ZERO)
    else $error("pixel counter did not wrap to zero");

  a_pixel_step_one: assert property (@(posedge pclk) disable iff (!presetn)
    !pix_wrap |=> frame_pixel_counter_ff
                  == $past(frame_pixel_counter_ff) + `VDFT_POS_ONE)
    else $error("pixel counter did not step by one");

  a_line_wrap_one: assert property (@(posedge pclk) disable iff (!presetn)
    pix_wrap && frame_line_counter_ff >= lines_per_frame_ff
    |=> frame_line_counter_ff == `VDFT_LINE_FIRST)
    else $error("line counter did not wrap to one");

  a_line_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !pix_wrap |=> $stable(frame_line_counter_ff))
    else $error("line counter moved without pixel wrap");

  a_hblank_begin: assert property (@(posedge pclk) disable iff (!presetn)
    at_begin |=> timing.horiz_blank_out)
    else $error("horizontal blanking not asserted at begin");

  a_hblank_end: assert property (@(posedge pclk) disable iff (!presetn)
    at_end && !at_begin && !(coded && blank_end_delay_en_ff)
    |=> !timing.horiz_blank_out)
    else $error("horizontal blanking not released at end");

  sequence s_delayed_end;
    at_end && !at_begin && coded && blank_end_delay_en_ff;
  endsequence

  sequence s_quiet_four;
    (!at_begin && !at_end) [*4];
  endsequence

  a_hblank_delayed: assert property (@(posedge pclk) disable iff (!presetn)
    s_delayed_end ##1 s_quiet_four |=> !timing.horiz_blank_out)
    else $error("delayed blanking release missing");

  a_hblank_held: assert property (@(posedge pclk) disable iff (!presetn)
    s_delayed_end ##1 timing.horiz_blank_out |=> timing.horiz_blank_out)
    else $error("delayed blanking released early");

  a_codes_raw: assert property (@(posedge pclk) disable iff (!presetn)
    !coded |=> !timing.eav_insert && !timing.sav_insert)
    else $error("timing code strobe in raw mode");

  a_eav_point: assert property (@(posedge pclk) disable iff (!presetn)
    at_begin && coded |=> timing.eav_insert)
    else $error("eav strobe missing");

  a_vblank_begin: assert property (@(posedge pclk) disable iff (!presetn)
    frame_line_counter_ff == f1_vblank_begin_line_ff
    && frame_pixel_counter_ff == f1_vblank_begin_pixel_ff
    |=> timing.vert_blank_out)
    else $error("vertical blanking not asserted");

endmodule : vdft_frame_timing

// [vdft_display_model.sv]
/*
  passive display receiver model: watches the timing outputs and keeps
  the counts and spans that the bench compares.
  assumes it shares pclk and presetn with the timing block.
*/
`timescale 1ns/100ps

module vdft_display_model (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // timing from the block
  input  vdft_pkg::vdft_timing_t timing,
  // measurements
  output int                    eav_cnt,
  output int                    sav_cnt,
  output int                    hb_len,
  output int                    hb_gap,
  output int                    eav_gap,
  output logic                  hb_at_sav
);
  import vdft_pkg::*;

  int   hb_run;
  int   gap_run;
  int   eav_run;
  logic hb_prev;

  // a receiver only sees edges and pulses, so spans are counted here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eav_cnt   <= 0;
      sav_cnt   <= 0;
      hb_len    <= 0;
      hb_gap    <= 0;
      eav_gap   <= 0;
      hb_at_sav <= 1'b0;
      hb_run    <= 0;
      gap_run   <= 0;
      eav_run   <= 0;
      hb_prev   <= 1'b0;
    end else begin
      hb_prev <= timing.horiz_blank_out;
      eav_run <= timing.eav_insert ? 1 : eav_run + 1;
      gap_run <= (timing.horiz_blank_out && !hb_prev) ? 1 : gap_run + 1;
      if (timing.eav_insert) begin
        eav_cnt <= eav_cnt + 1;
        eav_gap <= eav_run;
      end
      if (timing.sav_insert) begin
        sav_cnt   <= sav_cnt + 1;
        hb_at_sav <= timing.horiz_blank_out;
      end
      if (timing.horiz_blank_out && !hb_prev) begin
        hb_gap <= gap_run;
      end
      if (timing.horiz_blank_out) begin
        hb_run <= hb_run + 1;
      end else if (hb_run != 0) begin
        hb_len <= hb_run;
        hb_run <= 0;
      end
    end
  end
endmodule : vdft_display_model

// [test_video_display_frame_timing.sv]
/*
  self-checking bench for the frame timing block: register table rows,
  then counters, blanking, code strobes, modes and vertical blanking.
  assumes vdft_pkg and vdft_display_model are compiled before it.
*/
`timescale 1ns/100ps

module test_video_display_frame_timing;
  import vdft_pkg::*;

  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] rst;
    logic [31:0] exp;
    logic        err;
  } vdft_row_t;

  logic          pclk    = 1'b0;
  logic          presetn = 1'b0;
  logic          psel    = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite  = 1'b0;
  logic [11:0]   paddr   = 12'h000;
  logic [31:0]   pwdata  = 32'h0000_0000;
  vdft_apb_rsp_t apb_rsp;
  vdft_timing_t  timing;
  int            failures = 0;
  int            tests_run = 0;
  int            eav_cnt, sav_cnt, hb_len, hb_gap, eav_gap, n, ec, sc;
  logic          hb_at_sav;
  logic [31:0]   q;
  logic          e;
  logic [2:0]    md;

  // write all ones to show reserved bits drop; 525/858 is a real setting
  vdft_row_t rows [7] = '{
    '{12'h000, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0007, 1'b0},
    '{12'h004, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0FFF_0FFF, 1'b0},
    '{12'h004, 32'h020D_035A, 32'h0FFF_0FFF, 32'h020D_035A, 1'b0},
    '{12'h008, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0FFF_8FFF, 1'b0},
    '{12'h00C, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0FFF_0FFF, 1'b0},
    '{12'h010, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0001, 1'b0},
    '{12'h018, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 1'b1}};

  always #10 pclk = ~pclk;

  vdft_frame_timing u_vdft_frame_timing (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp),
    .timing(timing));

  vdft_display_model u_vdft_display_model (
    .pclk(pclk), .presetn(presetn), .timing(timing), .eav_cnt(eav_cnt),
    .sav_cnt(sav_cnt), .hb_len(hb_len), .hb_gap(hb_gap),
    .eav_gap(eav_gap), .hb_at_sav(hb_at_sav));

  task test_done;
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task chk_reg(input logic [31:0] got, input logic [31:0] exp, string m);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk_reg

  task chk_cnt(input int got, input int exp, input string m);
    tests_run++;
    if (got != exp) begin
      failures++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, m, got, exp);
    end
  endtask : chk_cnt

  // one transfer; request held until pready is seen at a rising edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failures++;
      $display("unexpected at %0t: no pready", $time);
      test_done();
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rst_dut;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    chk_reg(32'(timing), 32'h0000_0000, "outputs in reset");
    presetn <= 1'b1;
  endtask : rst_dut

  initial begin
    rst_dut();
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b0, 32'h0000_0000);
      chk_reg(q, rows[i].rst, "reset value");
      apb(rows[i].a, 1'b1, rows[i].d);
      chk_reg(32'(e), 32'(rows[i].err), "slave error");
      apb(rows[i].a, 1'b0, 32'h0000_0000);
      chk_reg(q, rows[i].exp, "read back");
    end
    // second reset also clears vertical blanking, which has no end here
    rst_dut();
    apb(12'h004, 1'b1, 32'h0003_000A);
    apb(12'h008, 1'b1, 32'h0004_8002);
    for (int m = 0; m < 8; m++) begin
      md = 3'(m);
      apb(12'h000, 1'b1, 32'(md));
      repeat (30) @(negedge pclk);
      ec = eav_cnt;
      sc = sav_cnt;
      repeat (20) @(negedge pclk);
      chk_cnt(eav_cnt - ec, md[1] ? 0 : 2, "eav count");
      chk_cnt(sav_cnt - sc, md[1] ? 0 : 2, "sav count");
      chk_cnt(hb_len, md[1] ? 2 : 6, "delayed blank");
      chk_cnt(hb_gap, 10, "line period");
    end
    apb(12'h000, 1'b1, 32'h0000_0000);
    apb(12'h008, 1'b1, 32'h0004_0002);
    repeat (30) @(negedge pclk);
    chk_cnt(hb_len, 2, "blank length");
    chk_reg(32'(hb_at_sav), 32'h0000_0000, "blank at sav");
    chk_cnt(eav_gap, 10, "eav period");
    apb(12'h00C, 1'b1, 32'h0000_0003);
    repeat (80) @(negedge pclk);
    chk_reg(32'(timing.vert_blank_out), 32'h0000_0000, "line zero");
    apb(12'h00C, 1'b1, 32'h0004_0003);
    repeat (80) @(negedge pclk);
    chk_reg(32'(timing.vert_blank_out), 32'h0, "line 4");
    apb(12'h00C, 1'b1, 32'h0003_0003);
    n = 0;
    while (timing.vert_blank_out !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk_cnt(n < 40 ? 1 : 0, 1, "vblank rise");
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (timing.eav_insert !== 1'b1 && n < 20);
    chk_cnt(n, 9, "vblank pixel");
    chk_reg(32'(timing.f1_vbit), 32'h0000_0000, "vbit low");
    apb(12'h010, 1'b1, 32'h0000_0001);
    // pixel 8 of the line: blanking and codes idle, vertical blanking held
    repeat (3) @(negedge pclk);
    chk_reg(32'(timing), 32'h0000_0009, "vbit high");
    test_done();
  end
endmodule : test_video_display_frame_timing
